//--- logic/bgis_pkg.sv
// Constants and types for the bus grant and input sampling block
package bgis_pkg;

	localparam int CLK_PERIOD_NS     = 20;
	localparam int LOCK_INPUT_CYCLES = 2000;
	localparam int RESET_MIN_CYCLES  = 5;
	localparam int EDGE_PULSE_NS     = 10;
	localparam int EDGE_PULSE_CYC    = (EDGE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int NUM_SELECTS = 5;
	localparam int NUM_IRQ     = 6;
	localparam int NUM_PF      = 8;
	localparam int NUM_FL      = 3;

	localparam logic [NUM_SELECTS-1:0] SELECTS_IDLE = 5'h1F;

	// Memory selects and strobes, all active low
	typedef struct packed {
		logic [NUM_SELECTS-1:0] memory_selects;
		logic                   read_n;
		logic                   write_n;
	} bgis_strobes_s;

	// Flag outputs that move together on the clock output fall
	typedef struct packed {
		logic [NUM_PF-1:0] pf_value;
		logic [NUM_PF-1:0] pf_oe;
		logic [NUM_FL-1:0] dedicated;
		logic              flag_output_pin;
	} bgis_flags_s;

	typedef enum logic [1:0] {
		BUS_OWNED,
		BUS_RELEASED,
		BUS_GRANTED,
		BUS_RECLAIM
	} bgis_bus_e;

endpackage

//--- logic/bgis_top.sv
// Clock generation, input sampling, flag outputs and bus grant handshake
`timescale 1ns/1ps
module bgis_top #(
	parameter int CNT_W  = 8,
	parameter int MODE_W = 4,
	parameter int LOCK_CYCLES = bgis_pkg::LOCK_INPUT_CYCLES
) (
	// Clock and reset
	input  wire logic                         i_mclk,
	input  wire logic                         i_reset_n,
	// Input clock and board reset
	input  wire logic                         i_input_clock,
	input  wire logic                         i_ext_reset_n,
	input  wire logic [MODE_W-1:0]            i_mode,
	// Interrupt and flag inputs
	input  wire logic [bgis_pkg::NUM_IRQ-1:0] i_irq_n,
	input  wire logic [bgis_pkg::NUM_PF-1:0]  i_pf_in,
	input  wire logic                         i_flag_input_pin,
	// Flag values from the core
	input  wire bgis_pkg::bgis_flags_s        i_flags,
	// Core memory access and bus needs
	input  wire bgis_pkg::bgis_strobes_s      i_strobes,
	input  wire logic                         i_core_needs_bus,
	input  wire logic                         i_byte_dma_needs_bus,
	// Bus request
	input  wire logic                         i_bus_request_n,
	// Clock and reset outputs
	output logic                              o_processor_clock_output,
	output logic                              o_pll_locked,
	output logic                              o_core_reset,
	output logic [MODE_W-1:0]                 o_mode,
	// Recognized inputs
	output logic [bgis_pkg::NUM_IRQ-1:0]      o_irq_level,
	output logic [bgis_pkg::NUM_IRQ-1:0]      o_irq_edge,
	output logic [bgis_pkg::NUM_PF-1:0]       o_pf_level,
	output logic                              o_flag_input,
	// Flag outputs
	output bgis_pkg::bgis_flags_s             o_flags,
	// Memory bus
	output bgis_pkg::bgis_strobes_s           o_strobes,
	output logic                              o_strobes_oe,
	output logic                              o_bus_grant_n,
	output logic                              o_grant_hang_n,
	output logic                              o_bus_request_seen
);

	// Elaboration check; the lock counter is only 16 bits wide
	if (CNT_W < 2 || CNT_W > 16 || MODE_W < 1 || LOCK_CYCLES < 1 || LOCK_CYCLES > 65535) begin : g_param_check
		$error("bgis_top: unsupported parameter values");
	end

	// Input clock edges
	logic             in_clk_q;
	logic             in_edge;
	logic             in_rise;
	logic [CNT_W-1:0] seg_cnt;
	logic [CNT_W-1:0] seg_len;
	logic [15:0]      lock_cnt;
	logic             proc_rise;
	logic             proc_fall;

	assign in_edge   = i_input_clock ^ in_clk_q;
	assign in_rise   = i_input_clock & ~in_clk_q;
	assign proc_rise = in_edge & o_pll_locked;
	assign proc_fall = o_pll_locked & ~in_edge & (seg_cnt == (seg_len >> 1));

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			in_clk_q <= 1'b0;
		end else begin
			in_clk_q <= i_input_clock;
		end
	end

	// Measures half the input period to place the mid-cycle fall
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			seg_cnt <= '0;
			seg_len <= '0;
		end else if (in_edge) begin
			seg_cnt <= CNT_W'(1);
			seg_len <= seg_cnt;
		end else if (seg_cnt != '1) begin
			seg_cnt <= seg_cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lock_cnt     <= '0;
			o_pll_locked <= 1'b0;
		end else if (in_rise && !o_pll_locked) begin
			lock_cnt     <= lock_cnt + 16'h0001;
			o_pll_locked <= (lock_cnt == 16'(LOCK_CYCLES - 1));
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_processor_clock_output <= 1'b0;
		end else if (proc_rise) begin
			o_processor_clock_output <= 1'b1;
		end else if (proc_fall || !o_pll_locked) begin
			o_processor_clock_output <= 1'b0;
		end
	end

	// Board reset width and mode capture
	// Width counts processor cycles, so nothing is counted before lock
	logic       ext_rst_q;
	logic [2:0] rst_cnt;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ext_rst_q <= 1'b1;
			rst_cnt   <= '0;
		end else begin
			ext_rst_q <= i_ext_reset_n;
			if (i_ext_reset_n)
				rst_cnt <= '0;
			else if (proc_rise && rst_cnt != 3'(bgis_pkg::RESET_MIN_CYCLES))
				rst_cnt <= rst_cnt + 3'h1;
		end
	end

	// Short pulses are ignored rather than half-resetting the core
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_core_reset <= 1'b1;
			o_mode       <= '0;
		end else if (!i_ext_reset_n && rst_cnt == 3'(bgis_pkg::RESET_MIN_CYCLES)) begin
			o_core_reset <= 1'b1;
		end else if (i_ext_reset_n && !ext_rst_q && o_core_reset) begin
			o_core_reset <= 1'b0;
			o_mode       <= i_mode;
		end
	end

	// Interrupt and flag input recognition at the clock output fall
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_irq_level  <= {bgis_pkg::NUM_IRQ{1'b1}};
			o_irq_edge   <= '0;
			o_pf_level   <= '0;
			o_flag_input <= 1'b0;
		end else if (proc_fall) begin
			o_irq_level  <= i_irq_n;
			o_irq_edge   <= o_irq_level & ~i_irq_n;
			o_pf_level   <= i_pf_in;
			o_flag_input <= i_flag_input_pin;
		end else begin
			o_irq_edge   <= '0;
		end
	end

	// Flag outputs
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_flags <= '0;
		end else if (proc_fall) begin
			o_flags <= i_flags;
		end
	end

	// Bus request synchroniser; the request may change at any time
	logic      br_meta;
	logic      br_sync;
	logic      br_seen;
	bgis_pkg::bgis_bus_e bus_state;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			br_meta <= 1'b1;
			br_sync <= 1'b1;
			br_seen <= 1'b0;
		end else begin
			br_meta <= i_bus_request_n;
			br_sync <= br_meta;
			if (proc_fall)
				br_seen <= ~br_sync;
		end
	end

	// The core owns the bus until the master's request is seen at a clock output rise
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			bus_state <= bgis_pkg::BUS_OWNED;
		end else begin
			case (bus_state)
				bgis_pkg::BUS_OWNED: begin
					if (br_seen && proc_rise)
						bus_state <= bgis_pkg::BUS_RELEASED;
				end
				bgis_pkg::BUS_RELEASED: begin
					bus_state <= bgis_pkg::BUS_GRANTED;
				end
				bgis_pkg::BUS_GRANTED: begin
					if (!br_seen)
						bus_state <= bgis_pkg::BUS_RECLAIM;
				end
				bgis_pkg::BUS_RECLAIM: begin
					bus_state <= bgis_pkg::BUS_OWNED;
				end
				default: begin
					bus_state <= bgis_pkg::BUS_OWNED;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_strobes_oe   <= 1'b1;
			o_bus_grant_n  <= 1'b1;
			o_grant_hang_n <= 1'b1;
		end else begin
			o_strobes_oe   <= (bus_state == bgis_pkg::BUS_OWNED) && !(br_seen && proc_rise);
			o_bus_grant_n  <= !(bus_state == bgis_pkg::BUS_RELEASED || bus_state == bgis_pkg::BUS_GRANTED) ||
				(bus_state == bgis_pkg::BUS_GRANTED && !br_seen);
			o_grant_hang_n <= !(bus_state == bgis_pkg::BUS_GRANTED && br_seen && !o_strobes_oe &&
				(i_core_needs_bus || i_byte_dma_needs_bus));
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_strobes          <= '{memory_selects: bgis_pkg::SELECTS_IDLE, read_n: 1'b1, write_n: 1'b1};
			o_bus_request_seen <= 1'b0;
		end else begin
			o_strobes          <= i_strobes;
			o_bus_request_seen <= br_seen;
		end
	end

	// Checks
	a_clk_rise_edge: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		proc_rise |=> o_processor_clock_output)
		else $error("clock output did not rise after input clock edge");

	a_lock_gates_clk: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		!o_pll_locked |=> !o_processor_clock_output)
		else $error("clock output ran before lock");

	a_one_cycle_half: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		$rose(o_processor_clock_output) |-> $past(in_edge))
		else $error("processor cycle started without input clock edge");

	a_irq_sampled: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		proc_fall |=> (o_irq_level == $past(i_irq_n)) && (o_flag_input == $past(i_flag_input_pin)))
		else $error("interrupt inputs not taken at clock output fall");

	a_pf_sampled: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		!proc_fall |=> $stable(o_pf_level))
		else $error("flag pin level changed away from clock output fall");

	a_flag_update: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		$changed(o_flags) |-> $past(proc_fall))
		else $error("flag outputs changed away from clock output fall");

	a_grant_after_release: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		$fell(o_bus_grant_n) |-> !o_strobes_oe && !$past(o_strobes_oe))
		else $error("grant asserted before strobes released");

	a_reclaim_order: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		$rose(o_strobes_oe) |-> o_bus_grant_n && $past(o_bus_grant_n))
		else $error("strobes driven before grant went high");

	a_hang_released: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		!o_grant_hang_n |-> !o_strobes_oe && !o_bus_grant_n)
		else $error("grant-hang low while bus not granted");

	a_br_recognize: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		(proc_fall && !br_sync) |=> br_seen)
		else $error("bus request not recognized at sampling point");

	a_reset_mode: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		$fell(o_core_reset) |-> (o_mode == $past(i_mode)) && $past(i_ext_reset_n))
		else $error("mode not captured at reset release");

	a_reclaim_gap: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		$rose(o_bus_grant_n) |=> !o_strobes_oe)
		else $error("strobes driven in the cycle after grant went high");

	a_edge_one_cycle: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		(o_irq_edge != '0) |=> (o_irq_edge == '0))
		else $error("interrupt edge pulse longer than one cycle");

	a_core_reset_width: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		$rose(o_core_reset) |-> $past(rst_cnt) == 3'(bgis_pkg::RESET_MIN_CYCLES))
		else $error("core reset taken from a short board reset pulse");

	a_grant_needs_request: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
		!o_bus_grant_n |-> o_bus_request_seen)
		else $error("bus granted without a recognized request");

	c_bus_granted: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
		$fell(o_bus_grant_n));
	c_bus_reclaimed: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
		$rose(o_strobes_oe));
	c_grant_hang: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
		$fell(o_grant_hang_n));
	c_core_release: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
		$fell(o_core_reset));
	c_irq_edge: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
		o_irq_edge != '0);

endmodule

//--- verif/bgis_bus_master.sv
// Behavioural outside bus master that borrows the memory bus
`timescale 1ns/1ps
module bgis_bus_master (
	// Clock and grant
	input  wire logic       i_mclk,
	input  wire logic       i_bus_grant_n,
	// Command from the bench
	input  wire logic       i_start,
	input  wire logic [7:0] i_hold,
	// Request pin
	output logic            o_bus_request_n
);
	int n;

	initial o_bus_request_n = 1'b1;

	always @(posedge i_mclk) begin
		if (i_start) begin
			@(negedge i_mclk);
			o_bus_request_n = 1'b0;
			n = 0;
			while (i_bus_grant_n !== 1'b0 && n < 64) begin
				@(negedge i_mclk);
				n++;
			end
			// Held for the whole use of the bus, short or long
			repeat (i_hold) @(negedge i_mclk);
			o_bus_request_n = 1'b1;
		end
	end
endmodule

//--- verif/bgis_top_test.sv
// Self-checking bench for the bus grant and input sampling block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, e, g); end end
`define WAITV(s, v, lim, nm) begin k = 0; while ((s) !== (v) && k < (lim)) begin @(negedge i_mclk); k++; end if (k >= (lim)) expire(nm); end
module bgis_top_test;
	localparam int HALF = 4;
	int                      n_fail;
	int                      num_checks;
	int                      k;
	logic                    i_mclk, i_reset_n, i_input_clock, i_ext_reset_n, i_flag_input_pin;
	logic [3:0]              i_mode, o_mode, exp_mode;
	logic [5:0]              i_irq_n, o_irq_level, o_irq_edge;
	logic [7:0]              i_pf_in, o_pf_level, m_hold;
	bgis_pkg::bgis_flags_s   i_flags, o_flags;
	bgis_pkg::bgis_strobes_s i_strobes, o_strobes;
	logic                    i_core_needs_bus, i_byte_dma_needs_bus, i_bus_request_n, m_start, oe_q;
	logic                    o_processor_clock_output, o_pll_locked, o_core_reset, o_flag_input;
	logic                    o_strobes_oe, o_bus_grant_n, o_grant_hang_n, o_bus_request_seen;

	// Short lock count keeps the run brief
	bgis_top #(.LOCK_CYCLES(4)) uut (.i_mclk, .i_reset_n, .i_input_clock, .i_ext_reset_n, .i_mode,
		.i_irq_n, .i_pf_in, .i_flag_input_pin, .i_flags, .i_strobes, .i_core_needs_bus,
		.i_byte_dma_needs_bus, .i_bus_request_n, .o_processor_clock_output, .o_pll_locked,
		.o_core_reset, .o_mode, .o_irq_level, .o_irq_edge, .o_pf_level, .o_flag_input, .o_flags,
		.o_strobes, .o_strobes_oe, .o_bus_grant_n, .o_grant_hang_n, .o_bus_request_seen);
	bgis_bus_master master (.i_mclk, .i_bus_grant_n(o_bus_grant_n), .i_start(m_start), .i_hold(m_hold),
		.o_bus_request_n(i_bus_request_n));

	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end
	initial begin
		i_input_clock = 1'b0;
		forever begin
			repeat (HALF) @(negedge i_mclk);
			i_input_clock = ~i_input_clock;
		end
	end
	always @(posedge i_mclk) oe_q <= o_strobes_oe;

	task automatic tick(input int n);
		repeat (n) @(negedge i_mclk);
	endtask

	task automatic expire(input string nm);
		n_fail++;
		$display("mismatch %s exp done got timeout", nm);
		final_report();
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic wait_fall;
		logic prev;
		int j;
		prev = o_processor_clock_output;
		for (j = 0; j < 4 * HALF; j++) begin
			@(negedge i_mclk);
			if (prev === 1'b1 && o_processor_clock_output === 1'b0) return;
			prev = o_processor_clock_output;
		end
		expire("clock fall");
	endtask

	task automatic check_clock;
		int lo;
		int hi;
		lo = 0;
		hi = 0;
		wait_fall();
		while (o_processor_clock_output !== 1'b1 && lo < 16) begin
			@(negedge i_mclk);
			lo++;
		end
		while (o_processor_clock_output === 1'b1 && hi < 16) begin
			@(negedge i_mclk);
			hi++;
		end
		`CHK("clock period", HALF, lo + hi)
		`CHK("clock high", HALF / 2, hi)
	endtask

	task automatic ext_pulse(input int cyc, input logic [3:0] mode);
		logic long_pulse;
		// Whole processor cycles past the minimum, one spare for the count
		long_pulse = cyc >= (bgis_pkg::RESET_MIN_CYCLES + 1) * HALF;
		i_ext_reset_n = 1'b0;
		tick(cyc);
		i_mode = mode;
		tick(1);
		`CHK("core reset held", long_pulse, o_core_reset)
		i_ext_reset_n = 1'b1;
		if (long_pulse)
			exp_mode = mode;
		tick(3);
		`CHK("core reset out", 1'b0, o_core_reset)
		`CHK("mode", exp_mode, o_mode)
	endtask

	task automatic check_sampling(input logic [5:0] irq, input logic [7:0] pf);
		logic [5:0] lvl_prev;
		bgis_pkg::bgis_flags_s old;
		wait_fall();
		lvl_prev = o_irq_level;
		old = o_flags;
		// Held a whole processor cycle, far past the pulse minimum
		i_irq_n = irq;
		i_pf_in = pf;
		i_flag_input_pin = ^pf;
		i_flags = {pf, ~pf, pf[2:0], ^pf};
		tick(1);
		`CHK("flags hold", old, o_flags)
		wait_fall();
		`CHK("irq level", irq, o_irq_level)
		`CHK("irq edge", lvl_prev & ~irq, o_irq_edge)
		`CHK("pf level", pf, o_pf_level)
		`CHK("flag in", ^pf, o_flag_input)
		`CHK("flags", i_flags, o_flags)
		tick(1);
		`CHK("irq edge end", 6'h00, o_irq_edge)
	endtask

	task automatic check_grant(input logic core, input logic dma, input logic [7:0] hold);
		int k;
		i_core_needs_bus = core;
		i_byte_dma_needs_bus = dma;
		m_hold = hold;
		m_start = 1'b1;
		tick(1);
		m_start = 1'b0;
		`WAITV(o_bus_request_seen, 1'b1, 3 * HALF + 4, "request seen")
		`WAITV(o_bus_grant_n, 1'b0, 3 * HALF, "grant")
		`CHK("released before grant", 1'b0, oe_q)
		`CHK("hang at grant", 1'b1, o_grant_hang_n)
		tick(2);
		`CHK("hang", ~(core | dma), o_grant_hang_n)
		`WAITV(o_bus_grant_n, 1'b1, hold + 4 * HALF, "reclaim")
		`CHK("oe at reclaim", 1'b0, o_strobes_oe)
		`CHK("hang release", 1'b1, o_grant_hang_n)
		tick(1);
		`CHK("oe gap", 1'b0, o_strobes_oe)
		tick(1);
		`CHK("driven again", 1'b1, o_strobes_oe)
		i_strobes = {5'h15, hold[1:0]};
		tick(2);
		`CHK("strobes", i_strobes, o_strobes)
	endtask

	initial begin
		n_fail = 0;
		num_checks = 0;
		i_reset_n = 1'b0;
		i_ext_reset_n = 1'b1;
		i_mode = 4'h0;
		i_irq_n = 6'h3F;
		i_pf_in = 8'h00;
		i_flag_input_pin = 1'b0;
		i_flags = '0;
		i_strobes = 7'h7F;
		i_core_needs_bus = 1'b0;
		i_byte_dma_needs_bus = 1'b0;
		m_start = 1'b0;
		m_hold = 8'h00;
		tick(2);
		`CHK("grant idle", 1'b1, o_bus_grant_n)
		`CHK("drive idle", 1'b1, o_strobes_oe)
		`CHK("clock idle", 1'b0, o_processor_clock_output)
		i_reset_n = 1'b1;
		tick(22);
		`CHK("early lock", 1'b0, o_pll_locked)
		`WAITV(o_pll_locked, 1'b1, 16, "lock")
		check_clock();
		ext_pulse(6 * HALF, 4'hA);
		ext_pulse(3 * HALF, 4'h5);
		ext_pulse(6 * HALF, 4'h6);
		check_sampling(6'h2A, 8'hC3);
		check_sampling(6'h3F, 8'h3C);
		check_sampling(6'h00, 8'hFF);
		check_grant(1'b1, 1'b0, 8'h02);
		check_grant(1'b0, 1'b1, 8'h14);
		check_grant(1'b0, 1'b0, 8'h03);
		final_report();
	end
endmodule
